// File: pkg/rop_defines.svh
// constants of the relay output port and its bus link
`ifndef ROP_DEFINES_SVH
`define ROP_DEFINES_SVH
`define ROP_CLK_MHZ 125
`define ROP_STROBE_MS 10
`define ROP_STROBE_CYC (`ROP_STROBE_MS * `ROP_CLK_MHZ * 1000)
`define ROP_FILTER_US 600
`define ROP_FILTER_CYC (`ROP_FILTER_US * `ROP_CLK_MHZ)
`define ROP_RELAY_PRESET 16'h0000
`define ROP_HOLD_CYC 4'h8
`define ROP_LEVEL_A 3'h5
`define ROP_LEVEL_B 3'h4
`define ROP_SI_LOW 0
`define ROP_SI_HIGH 1
`define ROP_SI_IEN_SET 2
`define ROP_SI_IEN_CLR 3
`define ROP_SI_READBACK 4
`define ROP_SI_STATUS 5
`define ROP_SI_GRANT 6
`define ROP_SI_BBSY 8
`define ROP_SI_SSYN 9
`define ROP_SI_RDY_RELAY 10
`define ROP_SI_RDY_LEVEL 11
`define ROP_SI_COUNT 12
`define ROP_REG_DATA 8'h00
`define ROP_REG_CMD 8'h04
`define ROP_REG_STATUS 8'h08
`define ROP_REG_PRIO 8'h0C
`define ROP_REG_READ 8'h10
`define ROP_REG_VECTOR 8'h14
`define ROP_CMD_LOW 0
`define ROP_CMD_HIGH 1
`define ROP_CMD_IEN_SET 2
`define ROP_CMD_IEN_CLR 3
`define ROP_CMD_READBACK 4
`define ROP_CMD_STATUS 5
`define ROP_CMD_VCLR 6
`define ROP_RESP_OKAY 2'h0
`define ROP_RESP_SLVERR 2'h2
`endif

// File: pkg/rop_pkg.sv
// types shared by both ends of the relay output port link
package rop_pkg;
    typedef logic [15:0] rop_word_t;
    typedef enum logic [3:0] {
        ROP_M_IDLE = 4'h1,
        ROP_M_REQ = 4'h2,
        ROP_M_ACK = 4'h4,
        ROP_M_OWN = 4'h8
    } rop_mst_e;
    typedef enum logic [2:0] {
        ROP_V_IDLE = 3'h1,
        ROP_V_SEND = 3'h2,
        ROP_V_DONE = 3'h4
    } rop_vec_e;
    typedef enum logic [3:0] {
        ROP_A_IDLE = 4'h1,
        ROP_A_GRANT = 4'h2,
        ROP_A_WAIT = 4'h4,
        ROP_A_HELD = 4'h8
    } rop_arb_e;
endpackage

// File: pkg/rop_link_if.sv
// shared bus between the relay output port and the processor end
`timescale 1ns/1ps
interface rop_link_if;
    logic [15:0] h_data;
    logic load_low;
    logic load_high;
    logic ien_set;
    logic ien_clear;
    logic readback_en;
    logic status_en;
    logic [15:0] d_data;
    logic d_data_oe;
    logic [1:0] priority_request;
    logic [1:0] priority_grant;
    logic selection_ack_line;
    logic bus_busy_line_dev;
    logic bus_busy_line_host;
    logic slave_sync_line;
    logic vector_strobe_line;
    modport dev (
        input h_data, load_low, load_high, ien_set, ien_clear, readback_en, status_en,
        input priority_grant, bus_busy_line_host, slave_sync_line,
        output d_data, d_data_oe, priority_request, selection_ack_line,
        output bus_busy_line_dev, vector_strobe_line
    );
    modport host (
        output h_data, load_low, load_high, ien_set, ien_clear, readback_en, status_en,
        output priority_grant, bus_busy_line_host, slave_sync_line,
        input d_data, d_data_oe, priority_request, selection_ack_line,
        input bus_busy_line_dev, vector_strobe_line
    );
endinterface

// File: rtl/rop_device_end.sv
// relay output port with two bus master channels and a vector sender
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "rop_defines.svh"
module rop_device_end #(
    parameter int STROBE_CYC = `ROP_STROBE_CYC,
    parameter int FILTER_CYC = `ROP_FILTER_CYC,
    parameter logic [15:0] PRESET = `ROP_RELAY_PRESET
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    rop_link_if.dev link,
    input wire logic [1:0] request_flag_in,
    input wire logic [1:0] request_enable_in,
    input wire logic [1:0] release_in,
    input wire logic [1:0] vector_start_in,
    input wire logic vector_bit_two_in,
    input wire logic [5:0] vector_links_in,
    input wire logic strobe_active_high_in,
    input wire logic ready_relay_in,
    input wire logic ready_level_in,
    output rop_pkg::rop_word_t relay_out,
    output logic [1:0] owner_out,
    output logic [1:0] vector_done_out,
    output logic [1:0] grant_chain_out,
    output logic strobe_driver_out,
    output logic strobe_oneshot_out,
    output logic int_flag_out,
    output logic int_enable_out
);
    import rop_pkg::*;

    logic [`ROP_SI_COUNT-1:0] raw;
    logic [`ROP_SI_COUNT-1:0] s1_q;
    logic [`ROP_SI_COUNT-1:0] s2_q;
    logic [`ROP_SI_COUNT-1:0] s3_q;
    logic [`ROP_SI_COUNT-1:0] sv_q;
    logic [`ROP_SI_COUNT-1:0] sp_q;
    wire [`ROP_SI_COUNT-1:0] rise = sv_q & ~sp_q;

    assign raw = {ready_level_in, ready_relay_in, link.slave_sync_line,
                  link.bus_busy_line_host, link.priority_grant, link.status_en,
                  link.readback_en, link.ien_clear, link.ien_set, link.load_high,
                  link.load_low};

    // three-stage sync, accepted when stages agree
    genvar gi;
    generate
        for (gi = 0; gi < `ROP_SI_COUNT; gi++) begin : g_sync
            always_ff @(posedge ref_clk_in) begin
                if (!nrst_in) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    sv_q[gi] <= 1'b0;
                    sp_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= raw[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        sv_q[gi] <= s3_q[gi];
                    end
                    sp_q[gi] <= sv_q[gi];
                end
            end
        end
    endgenerate

    wire load_lo = rise[`ROP_SI_LOW];
    wire load_hi = rise[`ROP_SI_HIGH];
    wire any_load = load_lo | load_hi;
    wire [1:0] grant_s = sv_q[`ROP_SI_GRANT +: 2];
    wire [1:0] grant_rise = rise[`ROP_SI_GRANT +: 2];
    wire bbsy_s = sv_q[`ROP_SI_BBSY];
    wire ssyn_s = sv_q[`ROP_SI_SSYN];

    // relay register, ready filter and flags
    logic [15:0] relay_q;
    logic [23:0] flt_cnt_q;
    logic ready_filt_q;
    logic ready_prev_q;
    logic iflag_q;
    logic ien_q;
    logic [23:0] os_cnt_q;
    logic driver_q;
    logic oneshot_q;

    // both ready forms share one filter
    wire ready_raw = sv_q[`ROP_SI_RDY_RELAY] | sv_q[`ROP_SI_RDY_LEVEL];
    wire flt_done = (flt_cnt_q == 24'(FILTER_CYC - 1));
    // rising edge of the filtered ready
    wire ready_rise = ready_filt_q & ~ready_prev_q;
    wire [23:0] os_cnt_d = any_load ? 24'(STROBE_CYC) :
                           (os_cnt_q != 24'h000000) ? os_cnt_q - 24'h000001 : os_cnt_q;

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            // preset per bit, never both ways
            relay_q <= PRESET;
            flt_cnt_q <= 24'h000000;
            ready_filt_q <= 1'b0;
            ready_prev_q <= 1'b0;
            iflag_q <= 1'b0;
            ien_q <= 1'b0;
            os_cnt_q <= 24'h000000;
            driver_q <= 1'b0;
            oneshot_q <= 1'b0;
        end else begin
            // byte lanes load apart or together
            if (load_lo) begin
                relay_q[7:0] <= link.h_data[7:0];
            end
            if (load_hi) begin
                relay_q[15:8] <= link.h_data[15:8];
            end
            if (ready_raw == ready_filt_q) begin
                flt_cnt_q <= 24'h000000;
            end else if (flt_done) begin
                flt_cnt_q <= 24'h000000;
                ready_filt_q <= ready_raw;
            end else begin
                flt_cnt_q <= flt_cnt_q + 24'h000001;
            end
            ready_prev_q <= ready_filt_q;
            // load clears flag, a new ready wins
            if (ready_rise) begin
                iflag_q <= 1'b1;
            end else if (any_load) begin
                iflag_q <= 1'b0;
            end
            // program sets and clears the enable
            if (rise[`ROP_SI_IEN_SET]) begin
                ien_q <= 1'b1;
            end else if (rise[`ROP_SI_IEN_CLR]) begin
                ien_q <= 1'b0;
            end
            driver_q <= any_load;
            os_cnt_q <= os_cnt_d;
            oneshot_q <= (os_cnt_d != 24'h000000) ? strobe_active_high_in
                                                   : ~strobe_active_high_in;
        end
    end

    // each register bit drives its relay
    assign relay_out = relay_q;
    assign strobe_driver_out = driver_q;
    assign strobe_oneshot_out = oneshot_q;
    assign int_flag_out = iflag_q;
    assign int_enable_out = ien_q;

    // bus master channels
    logic [1:0] req_d;
    logic [1:0] ack_d;
    logic [1:0] own_d;
    logic [1:0] gpass_d;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            rop_mst_e st_q;
            rop_mst_e st_d;
            wire act = request_flag_in[gi] & request_enable_in[gi];
            always_comb begin
                st_d = st_q;
                case (st_q)
                    ROP_M_IDLE: if (act) st_d = ROP_M_REQ;
                    ROP_M_REQ: begin
                        if (!act) st_d = ROP_M_IDLE;
                        else if (grant_rise[gi]) st_d = ROP_M_ACK;
                    end
                    // take the bus once it is free
                    ROP_M_ACK: begin
                        if (!act) st_d = ROP_M_IDLE;
                        else if (!grant_s[gi] && !bbsy_s && !ssyn_s) st_d = ROP_M_OWN;
                    end
                    // release or lost request ends it
                    ROP_M_OWN: if (release_in[gi] || !act) st_d = ROP_M_IDLE;
                    default: st_d = ROP_M_IDLE;
                endcase
            end
            always_ff @(posedge ref_clk_in) begin
                if (!nrst_in) begin
                    st_q <= ROP_M_IDLE;
                end else begin
                    st_q <= st_d;
                end
            end
            assign req_d[gi] = (st_d == ROP_M_REQ) || (st_d == ROP_M_ACK);
            assign ack_d[gi] = (st_d == ROP_M_ACK);
            assign own_d[gi] = (st_d == ROP_M_OWN);
            // pass the grant only when idle
            assign gpass_d[gi] = grant_s[gi] & (st_d == ROP_M_IDLE);
        end
    endgenerate

    // vector sender
    rop_vec_e vst_q;
    rop_vec_e vst_d;
    logic vch_q;
    wire vstart_any = |vector_start_in;
    always_comb begin
        vst_d = vst_q;
        case (vst_q)
            ROP_V_IDLE: if (vstart_any) vst_d = ROP_V_SEND;
            // sync from processor ends the send
            ROP_V_SEND: if (ssyn_s) vst_d = ROP_V_DONE;
            ROP_V_DONE: if (!vector_start_in[vch_q] && !ssyn_s) vst_d = ROP_V_IDLE;
            default: vst_d = ROP_V_IDLE;
        endcase
    end

    // inserted link forces a zero, bit two direct
    wire [15:0] vec_word = {7'h00, ~vector_links_in, vector_bit_two_in, 2'h0};
    wire rb_s = sv_q[`ROP_SI_READBACK];
    wire st_s = sv_q[`ROP_SI_STATUS];
    wire vsend_d = (vst_d == ROP_V_SEND);
    wire [15:0] drive_d = vsend_d ? vec_word :
                          rb_s ? relay_q :
                          st_s ? {14'h0000, ien_q, iflag_q} : 16'h0000;

    logic [1:0] req_q;
    logic sack_q;
    logic bbsy_q;
    logic [1:0] owner_q;
    logic [1:0] gpass_q;
    logic intr_q;
    logic [1:0] vdone_q;
    logic [15:0] dd_q;
    logic oe_q;
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            vst_q <= ROP_V_IDLE;
            vch_q <= 1'b0;
            req_q <= 2'h0;
            sack_q <= 1'b0;
            bbsy_q <= 1'b0;
            owner_q <= 2'h0;
            gpass_q <= 2'h0;
            intr_q <= 1'b0;
            vdone_q <= 2'h0;
            dd_q <= 16'h0000;
            oe_q <= 1'b0;
        end else begin
            vst_q <= vst_d;
            if (vst_q == ROP_V_IDLE && vstart_any) begin
                vch_q <= ~vector_start_in[0];
            end
            req_q <= req_d;
            sack_q <= |ack_d;
            bbsy_q <= |own_d;
            owner_q <= own_d;
            gpass_q <= gpass_d;
            intr_q <= vsend_d;
            // done drops the start, which ends it
            vdone_q <= (vst_d == ROP_V_DONE) ? (vch_q ? 2'h2 : 2'h1) : 2'h0;
            dd_q <= drive_d;
            oe_q <= vsend_d | rb_s | st_s;
        end
    end

    assign link.priority_request = req_q;
    assign link.selection_ack_line = sack_q;
    assign link.bus_busy_line_dev = bbsy_q;
    assign link.vector_strobe_line = intr_q;
    assign link.d_data = dd_q;
    assign link.d_data_oe = oe_q;
    assign owner_out = owner_q;
    assign grant_chain_out = gpass_q;
    assign vector_done_out = vdone_q;
endmodule // rop_device_end

// File: rtl/rop_host_end.sv
// processor end: arbiter, interrupt responder and command registers
`timescale 1ns/1ps
`include "rop_defines.svh"
module rop_host_end (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    rop_link_if.host link,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [7:0] s_axi_araddr_in,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out
);
    import rop_pkg::*;

    logic aw_got_q, w_got_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [15:0] data_q, rd_q, vec_q;
    logic [2:0] prio_q;
    logic vflag_q;
    logic [5:0] cmd_q;
    logic [3:0] hold_q;
    logic ssyn_q;
    logic [1:0] grant_q;
    logic gch_q;
    rop_arb_e ast_q;
    rop_arb_e ast_d;

    wire aw_hs = s_axi_awvalid_in & awready_q;
    wire w_hs = s_axi_wvalid_in & wready_q;
    wire do_wr = aw_got_q & w_got_q & ~bvalid_q;
    wire aw_got_d = (aw_got_q | aw_hs) & ~do_wr;
    wire w_got_d = (w_got_q | w_hs) & ~do_wr;
    wire bvalid_d = do_wr | (bvalid_q & ~s_axi_bready_in);
    wire ar_hs = s_axi_arvalid_in & arready_q;
    wire rvalid_d = ar_hs | (rvalid_q & ~s_axi_rready_in);
    wire wr_mapped = (awaddr_q == `ROP_REG_DATA) || (awaddr_q == `ROP_REG_CMD) ||
                     (awaddr_q == `ROP_REG_PRIO);
    wire busy = (hold_q != 4'h0);
    wire cmd_wr = do_wr & (awaddr_q == `ROP_REG_CMD) & wstrb_q[0];
    wire cmd_go = cmd_wr & ~busy & (ast_q == ROP_A_IDLE) & ~link.bus_busy_line_dev;
    wire [15:0] status_w = {10'h000, link.priority_request, vflag_q,
                            (ast_q != ROP_A_IDLE), link.bus_busy_line_dev, busy};
    wire [15:0] rd_mux = (s_axi_araddr_in == `ROP_REG_DATA) ? data_q :
                         (s_axi_araddr_in == `ROP_REG_STATUS) ? status_w :
                         (s_axi_araddr_in == `ROP_REG_PRIO) ? {13'h0000, prio_q} :
                         (s_axi_araddr_in == `ROP_REG_READ) ? rd_q :
                         (s_axi_araddr_in == `ROP_REG_VECTOR) ? vec_q : 16'h0000;
    wire rd_mapped = (s_axi_araddr_in == `ROP_REG_DATA) || (s_axi_araddr_in == `ROP_REG_CMD) ||
                     (s_axi_araddr_in == `ROP_REG_STATUS) || (s_axi_araddr_in == `ROP_REG_PRIO) ||
                     (s_axi_araddr_in == `ROP_REG_READ) || (s_axi_araddr_in == `ROP_REG_VECTOR);

    // level must exceed the held priority
    wire elig_a = link.priority_request[0] & (`ROP_LEVEL_A > prio_q);
    wire elig_b = link.priority_request[1] & (`ROP_LEVEL_B > prio_q);
    always_comb begin
        ast_d = ast_q;
        case (ast_q)
            ROP_A_IDLE: if (!busy && !link.bus_busy_line_dev && (elig_a || elig_b)) ast_d = ROP_A_GRANT;
            ROP_A_GRANT: begin
                if (link.selection_ack_line) ast_d = ROP_A_WAIT;
                else if (!link.priority_request[gch_q]) ast_d = ROP_A_IDLE;
            end
            ROP_A_WAIT: begin
                if (link.bus_busy_line_dev) ast_d = ROP_A_HELD;
                else if (!link.selection_ack_line) ast_d = ROP_A_IDLE;
            end
            ROP_A_HELD: if (!link.bus_busy_line_dev) ast_d = ROP_A_IDLE;
            default: ast_d = ROP_A_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `ROP_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `ROP_RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            data_q <= 16'h0000;
            prio_q <= 3'h0;
            rd_q <= 16'h0000;
            vec_q <= 16'h0000;
            vflag_q <= 1'b0;
            cmd_q <= 6'h00;
            hold_q <= 4'h0;
            ssyn_q <= 1'b0;
            grant_q <= 2'h0;
            gch_q <= 1'b0;
            ast_q <= ROP_A_IDLE;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awready_q <= ~aw_got_d & ~bvalid_d;
            wready_q <= ~w_got_d & ~bvalid_d;
            bvalid_q <= bvalid_d;
            arready_q <= ~rvalid_d;
            rvalid_q <= rvalid_d;
            if (aw_hs) awaddr_q <= s_axi_awaddr_in;
            if (w_hs) begin
                wdata_q <= s_axi_wdata_in;
                wstrb_q <= s_axi_wstrb_in;
            end
            if (ar_hs) begin
                rdata_q <= {16'h0000, rd_mux};
                rresp_q <= rd_mapped ? `ROP_RESP_OKAY : `ROP_RESP_SLVERR;
            end
            if (do_wr) begin
                bresp_q <= wr_mapped ? `ROP_RESP_OKAY : `ROP_RESP_SLVERR;
                if (awaddr_q == `ROP_REG_DATA && wstrb_q[0]) data_q[7:0] <= wdata_q[7:0];
                if (awaddr_q == `ROP_REG_DATA && wstrb_q[1]) data_q[15:8] <= wdata_q[15:8];
                if (awaddr_q == `ROP_REG_PRIO && wstrb_q[0]) prio_q <= wdata_q[2:0];
            end
            // strobes stand for the hold time; a busy command is dropped
            if (cmd_go && wdata_q[5:0] != 6'h00) begin
                cmd_q <= wdata_q[5:0];
                hold_q <= `ROP_HOLD_CYC;
            end else if (busy) begin
                hold_q <= hold_q - 4'h1;
                if (hold_q == 4'h1) begin
                    cmd_q <= 6'h00;
                    if (link.d_data_oe) rd_q <= link.d_data;
                end
            end
            // sync answers interrupt, drops after it
            if (!ssyn_q && link.vector_strobe_line) begin
                ssyn_q <= 1'b1;
                vec_q <= link.d_data;
                vflag_q <= 1'b1;
            end else begin
                if (ssyn_q && !link.vector_strobe_line) ssyn_q <= 1'b0;
                if (cmd_wr && wdata_q[`ROP_CMD_VCLR]) vflag_q <= 1'b0;
            end
            ast_q <= ast_d;
            if (ast_q == ROP_A_IDLE) gch_q <= ~elig_a;
            // one grant, channel a ranks first
            grant_q <= (ast_d == ROP_A_GRANT) ? ((ast_q == ROP_A_IDLE ? ~elig_a : gch_q) ? 2'h2 : 2'h1)
                                              : 2'h0;
        end
    end

    assign s_axi_awready_out = awready_q;
    assign s_axi_wready_out = wready_q;
    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_arready_out = arready_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rdata_out = rdata_q;
    assign s_axi_rresp_out = rresp_q;
    assign link.h_data = data_q;
    assign link.load_low = cmd_q[`ROP_CMD_LOW];
    assign link.load_high = cmd_q[`ROP_CMD_HIGH];
    assign link.ien_set = cmd_q[`ROP_CMD_IEN_SET];
    assign link.ien_clear = cmd_q[`ROP_CMD_IEN_CLR];
    assign link.readback_en = cmd_q[`ROP_CMD_READBACK];
    assign link.status_en = cmd_q[`ROP_CMD_STATUS];
    assign link.bus_busy_line_host = busy;
    assign link.slave_sync_line = ssyn_q;
    assign link.priority_grant = grant_q;
endmodule // rop_host_end

// File: testbench/rop_link_sva.sv
// concurrent checks on the shared link between both ends
`timescale 1ns/1ps
module rop_link_sva (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [15:0] d_data,
    input wire logic d_data_oe,
    input wire logic readback_en,
    input wire logic status_en,
    input wire logic [1:0] priority_grant,
    input wire logic selection_ack_line,
    input wire logic bus_busy_line_dev,
    input wire logic bus_busy_line_host,
    input wire logic slave_sync_line,
    input wire logic vector_strobe_line
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    a_vector_field: assert property (vector_strobe_line |-> d_data[15:9] == 7'h00 && d_data[1:0] == 2'h0)
        else $error("vector outside bits 8 to 2");
    a_ack_on_grant: assert property ($rose(selection_ack_line) |-> priority_grant != 2'h0)
        else $error("acknowledge without grant");
    a_grant_withdrawn: assert property (selection_ack_line |-> ##[0:2] priority_grant == 2'h0)
        else $error("grant kept after acknowledge");
    a_busy_when_free: assert property ($rose(bus_busy_line_dev) |->
        !selection_ack_line && !slave_sync_line && !bus_busy_line_host)
        else $error("bus taken while not free");
    a_strobe_holds: assert property ($rose(vector_strobe_line) |-> vector_strobe_line [*3])
        else $error("vector strobe dropped early");
    a_strobe_drops: assert property (slave_sync_line |-> ##[1:8] !vector_strobe_line)
        else $error("vector strobe kept after sync");
    a_readback_drive: assert property ($rose(readback_en) |-> ##[1:8] d_data_oe)
        else $error("readback not driven");
    a_status_drive: assert property ($rose(status_en) |-> ##[1:8] d_data_oe)
        else $error("status not driven");
    cover property ($rose(bus_busy_line_dev));
    cover property ($rose(slave_sync_line));
    cover property ($rose(readback_en));
endmodule // rop_link_sva

// File: testbench/test_relay_output_port_with_bus_interrupt.sv
// self-checking bench for both ends of the relay port link
`timescale 1ns/1ps
module test_relay_output_port_with_bus_interrupt;
    import rop_pkg::*;
    logic ref_clk_in = 1'b0, nrst_in = 1'b0, s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
    logic s_axi_bready_in = 1'b1, s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b1;
    logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, rd_data;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rd_resp;
    logic [1:0] request_flag_in = 2'h0, request_enable_in = 2'h0, release_in = 2'h0;
    logic [1:0] vector_start_in = 2'h0, owner_out, vector_done_out;
    logic vector_bit_two_in = 1'b1, strobe_active_high_in = 1'b1;
    logic ready_relay_in = 1'b0, ready_level_in = 1'b0;
    logic [5:0] vector_links_in = 6'h2A;
    rop_word_t relay_out;
    logic strobe_driver_out, strobe_oneshot_out, int_flag_out, int_enable_out;
    logic [5:0] ev;
    int failures = 0, comparisons = 0;
    rop_link_if link ();
    assign ev = {strobe_driver_out, strobe_oneshot_out, vector_done_out[0], owner_out, int_flag_out};
    // short counts keep the runs brief
    rop_device_end #(.STROBE_CYC(20), .FILTER_CYC(10)) u_rop_device_end (.ref_clk_in, .nrst_in,
        .link, .request_flag_in, .request_enable_in, .release_in, .vector_start_in,
        .vector_bit_two_in, .vector_links_in, .strobe_active_high_in, .ready_relay_in,
        .ready_level_in, .relay_out, .owner_out, .vector_done_out, .grant_chain_out(),
        .strobe_driver_out, .strobe_oneshot_out, .int_flag_out, .int_enable_out);
    rop_host_end u_rop_host_end (.ref_clk_in, .nrst_in, .link, .s_axi_awvalid_in,
        .s_axi_awready_out, .s_axi_awaddr_in, .s_axi_wvalid_in, .s_axi_wready_out,
        .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out,
        .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_araddr_in, .s_axi_rvalid_out,
        .s_axi_rready_in, .s_axi_rdata_out, .s_axi_rresp_out);
    rop_link_sva u_rop_link_sva (.ref_clk_in, .nrst_in, .d_data(link.d_data),
        .d_data_oe(link.d_data_oe), .readback_en(link.readback_en), .status_en(link.status_en),
        .priority_grant(link.priority_grant), .selection_ack_line(link.selection_ack_line),
        .bus_busy_line_dev(link.bus_busy_line_dev), .bus_busy_line_host(link.bus_busy_line_host),
        .slave_sync_line(link.slave_sync_line), .vector_strobe_line(link.vector_strobe_line));
    always #4 ref_clk_in = ~ref_clk_in;
    task automatic close_out();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic hang();
        failures++;
        close_out();
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
            if (++n > 99) hang();
        end while (s_axi_bvalid_out !== 1'b1);
    endtask
    // busy commands are ignored
    task automatic cmd(input logic [31:0] d);
        wr(8'h04, d);
        repeat (12) @(posedge ref_clk_in);
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
            if (++n > 99) hang();
        end while (s_axi_rvalid_out !== 1'b1);
        rd_data = s_axi_rdata_out;
        rd_resp = s_axi_rresp_out;
    endtask
    task automatic wait_ev(input int k, input logic v);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk_in);
            if (++n > 400) hang();
        end while (ev[k] !== v);
    endtask
    initial begin
        repeat (2) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        chk("relay", 32'(relay_out), 32'h0);
        chk("flags", 32'({int_flag_out, int_enable_out}), 32'h0);
        wr(8'h00, 32'h0000A55A);
        wr(8'h04, 32'h00000003);
        wait_ev(5, 1'b1);
        wait_ev(4, 1'b1);
        wait_ev(4, 1'b0);
        chk("relay", 32'(relay_out), 32'h0000A55A);
        wr(8'h00, 32'h00001234);
        cmd(32'h00000001);
        chk("relay", 32'(relay_out), 32'h0000A534);
        cmd(32'h00000004);
        cmd(32'h00000020);
        rd(8'h10);
        chk("status", rd_data, 32'h00000002);
        ready_relay_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        ready_relay_in <= 1'b0;
        repeat (30) @(posedge ref_clk_in);
        chk("flag", 32'(int_flag_out), 32'h0);
        ready_level_in <= 1'b1;
        wait_ev(0, 1'b1);
        ready_level_in <= 1'b0;
        cmd(32'h00000010);
        rd(8'h10);
        chk("readback", rd_data, 32'h0000A534);
        cmd(32'h00000008);
        chk("enable", 32'(int_enable_out), 32'h0);
        strobe_active_high_in <= 1'b0;
        cmd(32'h00000001);
        chk("flag", 32'(int_flag_out), 32'h0);
        chk("oneshot", 32'(strobe_oneshot_out), 32'h0);
        wr(8'h0C, 32'h0);
        request_flag_in <= 2'h1;
        request_enable_in <= 2'h1;
        wait_ev(1, 1'b1);
        release_in <= 2'h1;
        repeat (2) @(posedge ref_clk_in);
        chk("owner", 32'(owner_out), 32'h0);
        release_in <= 2'h0;
        request_flag_in <= 2'h0;
        wr(8'h0C, 32'h4);
        request_flag_in <= 2'h2;
        request_enable_in <= 2'h2;
        repeat (60) @(posedge ref_clk_in);
        chk("owner", 32'(owner_out), 32'h0);
        wr(8'h0C, 32'h3);
        wait_ev(2, 1'b1);
        request_enable_in <= 2'h0;
        repeat (2) @(posedge ref_clk_in);
        chk("owner", 32'(owner_out), 32'h0);
        vector_start_in <= 2'h1;
        wait_ev(3, 1'b1);
        vector_start_in <= 2'h0;
        rd(8'h14);
        chk("vector", rd_data, 32'h000000AC);
        rd(8'hFC);
        chk("resp", 32'(rd_resp), 32'h2);
        close_out();
    end
endmodule // test_relay_output_port_with_bus_interrupt
